// file: hw/memory_map_and_banking.sv
// Program fetch address and data bank decoder for the core
// Notes on behaviour
// - Program counter 13 bits, 8K word space
// - Only 2K words exist; higher addresses wrap
// - Fetch starts at address zero after reset
// - Interrupt redirects fetch to address four
// - Separate fetch and data buses, concurrent
// - Bank bits choose bank; banks 2,3 absent
// - Each bank spans 128 bytes
// - Low addresses control regs, above scratch RAM
// - Top 16 scratch and hot regs mirrored
// - Access direct or through pointer register
`default_nettype none
module memory_map_and_banking #(
    parameter int PROG_IMPL_BITS = mem_map_pkg::PROG_IMPL_WIDTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    // Fetch side
    input wire logic fetchAdvance,
    input wire logic jumpValid,
    input wire logic [12:0] jumpTarget,
    input wire logic irqTake,
    output logic [12:0] progCounter,
    output logic [10:0] progMemAddr,
    // Data side
    input wire logic dataReq,
    input wire logic dataWrite,
    input wire logic [6:0] dataOffset,
    input wire logic [7:0] dataWdata,
    input wire logic [7:0] statusIn,
    output logic [7:0] dataRdata,
    output logic dataValid,
    output logic [7:0] indirectPointer,
    output logic [8:0] dataAddr,
    output logic controlSel,
    output logic scratchSel,
    output logic unimplSel
);
    typedef enum logic [0:0] {
        ST_RESET = 1'b0,
        ST_RUN = 1'b1
    } fetch_state_t;

    typedef struct packed {
        fetch_state_t fetchState;
        logic [12:0] pc;
        logic [10:0] progAddr;
        logic [7:0] pointer;
        logic [8:0] dataAddr;
        logic controlSel;
        logic scratchSel;
        logic unimplSel;
        logic pendRead;
        logic pendScratch;
        logic pendPointerRd;
        logic dataValid;
        logic [7:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [7:0] ramRdata;
    logic ramWe;
    logic [7:0] ramAddr;

    // Fold mirrored scratch bytes of bank 1 onto bank 0 storage
    function automatic logic [7:0] scratch_index(input logic [1:0] bank, input logic [6:0] off);
        logic [7:0] idx;
        idx = {bank[0], off};
        if (bank == mem_map_pkg::BANK1 && off >= mem_map_pkg::MIRROR_BASE) begin
            idx = {1'b0, off};
        end
        return idx;
    endfunction

    function automatic logic is_control(input logic [6:0] off);
        return off < mem_map_pkg::SCRATCH_BASE;
    endfunction

    // Pointer slot reachable from either bank (hot register mirror)
    logic [1:0] bankSel;
    logic [6:0] effOffset;
    logic indirect;

    always_comb begin
        s_d = s_q;
        s_d.dataValid = 1'b0;
        indirect = (dataOffset == mem_map_pkg::INDIRECT_SLOT);
        // direct: bank bits join the 7-bit offset
        bankSel = {statusIn[mem_map_pkg::STATUS_BANK_HI_BIT],
                   statusIn[mem_map_pkg::STATUS_BANK_LO_BIT]};
        effOffset = dataOffset;
        if (indirect) begin
            // Indirect bank from the pointer top bit and the status bit above it
            bankSel = {statusIn[mem_map_pkg::STATUS_IND_BANK_BIT], s_q.pointer[7]};
            effOffset = s_q.pointer[6:0];
        end
        ramAddr = scratch_index(bankSel, effOffset);
        ramWe = 1'b0;
        // Fetch side runs independently of the data side
        case (s_q.fetchState)
            ST_RESET: begin
                s_d.pc = mem_map_pkg::RESET_VECTOR;
                s_d.fetchState = ST_RUN;
            end
            ST_RUN: begin
                if (irqTake) begin
                    s_d.pc = mem_map_pkg::IRQ_VECTOR;
                end else if (jumpValid) begin
                    s_d.pc = jumpTarget;
                end else if (fetchAdvance) begin
                    s_d.pc = s_q.pc + 13'h0001;
                end
            end
            default: s_d.fetchState = ST_RESET;
        endcase
        s_d.progAddr = s_d.pc[10:0] & 11'((1 << PROG_IMPL_BITS) - 1);
        s_d.pendRead = 1'b0;
        s_d.pendScratch = 1'b0;
        s_d.pendPointerRd = 1'b0;
        if (dataReq) begin
            s_d.dataAddr = {bankSel, effOffset};
            s_d.unimplSel = bankSel[1];
            s_d.controlSel = !bankSel[1] && is_control(effOffset);
            s_d.scratchSel = !bankSel[1] && !is_control(effOffset);
            if (!bankSel[1] && effOffset == mem_map_pkg::POINTER_SLOT) begin
                if (dataWrite) begin
                    s_d.pointer = dataWdata;
                end else begin
                    s_d.pendPointerRd = 1'b1;
                end
            end
            if (!bankSel[1] && !is_control(effOffset)) begin
                ramWe = dataWrite;
                s_d.pendScratch = !dataWrite;
            end
            s_d.pendRead = !dataWrite;
            s_d.dataValid = dataWrite;
        end
        if (s_q.pendRead) begin
            s_d.dataValid = 1'b1;
            // Control registers other than the pointer live in the core; read as zero here
            s_d.rdata = s_q.pendScratch ? ramRdata :
                        (s_q.pendPointerRd ? s_q.pointer : mem_map_pkg::ZERO_BYTE);
        end
    end

    // Read latency is two cycles so RAM output can settle into a register
    scratch_ram #(
        .AW(mem_map_pkg::RAM_ADDR_WIDTH),
        .DW(mem_map_pkg::DATA_WIDTH)
    ) u_ram (
        .clk(clk),
        .writeEn(ramWe),
        .writeAddr(ramAddr),
        .writeData(dataWdata),
        .readAddr(ramAddr),
        .readData(ramRdata)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign progCounter = s_q.pc;
    assign progMemAddr = s_q.progAddr;
    assign dataRdata = s_q.rdata;
    assign dataValid = s_q.dataValid;
    assign indirectPointer = s_q.pointer;
    assign dataAddr = s_q.dataAddr;
    assign controlSel = s_q.controlSel;
    assign scratchSel = s_q.scratchSel;
    assign unimplSel = s_q.unimplSel;
endmodule // memory_map_and_banking
`default_nettype wire

// file: hw/mem_map_pkg.sv
// Constants for the program and data memory address decoder
`default_nettype none
package mem_map_pkg;
    localparam int PC_WIDTH = 13;
    localparam int PROG_IMPL_WIDTH = 11;
    localparam int INSTR_WIDTH = 14;
    localparam int DATA_WIDTH = 8;
    localparam int OFFSET_WIDTH = 7;
    localparam int BANK_WIDTH = 2;
    localparam int RAM_ADDR_WIDTH = 8;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [1:0] BANK0 = 2'h0;
    localparam logic [1:0] BANK1 = 2'h1;
    localparam logic [6:0] SCRATCH_BASE = 7'h20;
    localparam logic [6:0] SCRATCH_TOP = 7'h7F;
    localparam logic [6:0] MIRROR_BASE = 7'h70;
    localparam logic [6:0] INDIRECT_SLOT = 7'h00;
    localparam logic [6:0] PCL_SLOT = 7'h02;
    localparam logic [6:0] STATUS_SLOT = 7'h03;
    localparam logic [6:0] POINTER_SLOT = 7'h04;
    localparam logic [6:0] PCLATH_SLOT = 7'h0A;
    localparam logic [6:0] INTCON_SLOT = 7'h0B;
    localparam int STATUS_BANK_LO_BIT = 5;
    localparam int STATUS_BANK_HI_BIT = 6;
    localparam int STATUS_IND_BANK_BIT = 7;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage
`default_nettype wire

// file: hw/scratch_ram.sv
// Scratch storage memory with registered read data
`default_nettype none
module scratch_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic writeEn,
    input wire logic [AW-1:0] writeAddr,
    input wire logic [DW-1:0] writeData,
    input wire logic [AW-1:0] readAddr,
    output logic [DW-1:0] readData
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
        readData <= mem[readAddr];
    end
endmodule // scratch_ram
`default_nettype wire

// file: sim/mem_map_monitor.sv
// Checker on the decoder's top-level ports
`default_nettype none
module mem_map_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic fetchAdvance,
    input wire logic jumpValid,
    input wire logic irqTake,
    input wire logic [12:0] progCounter,
    input wire logic [10:0] progMemAddr,
    input wire logic dataReq,
    input wire logic dataWrite,
    input wire logic [6:0] dataOffset,
    input wire logic [7:0] statusIn,
    input wire logic [7:0] dataRdata,
    input wire logic dataValid,
    input wire logic [8:0] dataAddr,
    input wire logic scratchSel,
    input wire logic unimplSel
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_prog_wrap: assert property (progMemAddr == progCounter[10:0])
        else $error("fetch address not wrapped");
    a_reset_vector: assert property (disable iff (1'b0) sys_rst |=> progCounter == 13'h0000)
        else $error("pc not at reset vector");
    a_irq_vector: assert property (irqTake |=> progCounter == 13'h0004)
        else $error("pc not at interrupt vector");
    a_pc_step: assert property (fetchAdvance && !irqTake && !jumpValid |=>
        progCounter == $past(progCounter) + 13'h0001)
        else $error("pc step wrong");
    a_direct_addr: assert property (dataReq && dataOffset != 7'h00 |=>
        dataAddr == {$past(statusIn[6:5]), $past(dataOffset)})
        else $error("direct address wrong");
    a_scratch_decode: assert property (dataReq && !statusIn[6] && dataOffset >= 7'h20 |=>
        scratchSel && !unimplSel)
        else $error("scratch decode wrong");
    a_unimpl_bank: assert property (dataReq && !dataWrite && statusIn[6] && dataOffset != 7'h00
        |=> unimplSel ##1 dataRdata == 8'h00)
        else $error("absent bank not refused");
    a_read_latency: assert property (dataReq && !dataWrite |-> ##2 dataValid)
        else $error("read data late");
endmodule // mem_map_monitor
bind memory_map_and_banking mem_map_monitor mem_map_monitor_i (.*);
`default_nettype wire

// file: sim/core_model.sv
// Core-side model that forms the status byte
`default_nettype none
module core_model (
    input wire logic [1:0] bankReq,
    input wire logic allowHigh,
    output logic [7:0] statusIn
);
    // Upper bank bit kept clear unless a refusal test asks for it
    assign statusIn = {1'b0, allowHigh & bankReq[1], bankReq[0], 5'h00};
endmodule // core_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the memory map decoder
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, sys_rst = 1'b1, fetchAdvance = 1'b0, jumpValid = 1'b0, irqTake = 1'b0;
    logic dataReq = 1'b0, dataWrite = 1'b0, allowHigh = 1'b0, dataValid;
    logic controlSel, scratchSel, unimplSel;
    logic [12:0] jumpTarget = 13'h0000, progCounter;
    logic [10:0] progMemAddr;
    logic [6:0] dataOffset = 7'h00;
    logic [7:0] dataWdata = 8'h00, statusIn, dataRdata, indirectPointer, rd;
    logic [1:0] bankReq = 2'h0;
    logic [8:0] dataAddr;
    int err_total = 0, n_compared = 0, cycles = 0;
    always #2.5 clk = ~clk;
    core_model core_model_i (.bankReq(bankReq), .allowHigh(allowHigh), .statusIn(statusIn));
    memory_map_and_banking memory_map_and_banking_i (.*);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Request held one edge; reads answer one edge later than writes
    task automatic acc(input logic [1:0] b, input logic [6:0] o, input logic w, input logic [7:0] d);
        bankReq = b;
        dataOffset = o;
        dataWrite = w;
        dataWdata = d;
        dataReq = 1'b1;
        step();
        dataReq = 1'b0;
        if (!w) step();
        chk(dataValid, 1'b1);
        rd = dataRdata;
        // Idle edge so the next call never re-raises dataReq in this time step
        step();
    endtask
    task automatic t_fetch();
        jumpTarget = 13'h17FF;
        jumpValid = 1'b1;
        step();
        jumpValid = 1'b0;
        chk(progMemAddr, 11'h7FF);
        fetchAdvance = 1'b1;
        step();
        fetchAdvance = 1'b0;
        chk(progCounter, 13'h1800);
        chk(progMemAddr, 11'h000);
    endtask
    task automatic t_concurrent();
        irqTake = 1'b1;
        acc(2'h0, 7'h7E, 1'b1, 8'hA5);
        irqTake = 1'b0;
        chk(progCounter, 13'h0004);
        acc(2'h1, 7'h7E, 1'b0, 8'h00);
        chk(rd, 8'hA5);
        chk(dataAddr, 9'h0FE);
        chk(scratchSel, 1'b1);
    endtask
    task automatic t_indirect();
        acc(2'h0, 7'h04, 1'b1, 8'h35);
        acc(2'h0, 7'h00, 1'b1, 8'h5A);
        acc(2'h1, 7'h35, 1'b1, 8'hC3);
        acc(2'h1, 7'h04, 1'b0, 8'h00);
        chk(rd, 8'h35);
        chk(indirectPointer, 8'h35);
        acc(2'h0, 7'h35, 1'b0, 8'h00);
        chk(rd, 8'h5A);
        acc(2'h0, 7'h0B, 1'b0, 8'h00);
        chk(controlSel, 1'b1);
    endtask
    task automatic t_unimpl();
        allowHigh = 1'b1;
        acc(2'h2, 7'h35, 1'b1, 8'hFF);
        acc(2'h2, 7'h35, 1'b0, 8'h00);
        chk(rd, 8'h00);
        chk(unimplSel, 1'b1);
        chk(dataAddr, 9'h135);
        allowHigh = 1'b0;
        acc(2'h0, 7'h35, 1'b0, 8'h00);
        chk(rd, 8'h5A);
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        step();
        chk(progCounter, 13'h0000);
        t_fetch();
        t_concurrent();
        t_indirect();
        t_unimpl();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
